// *** src/dce_mag.sv ***
`timescale 1ns/1ps
module dce_mag #(
   parameter int IW = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // phasor sample
   input wire logic in_valid,
   input wire logic signed [IW-1:0] in_re,
   input wire logic signed [IW-1:0] in_im,
   // magnitude estimate
   output logic [IW:0] mag
);
   typedef struct packed {
      logic [IW:0] mag;
   } dce_mag_st_s;
   dce_mag_st_s st;
   dce_mag_st_s st_next;
   logic [IW-1:0] a_re;
   logic [IW-1:0] a_im;
   logic [IW-1:0] hi;
   logic [IW-1:0] lo;

   // unsigned abs holds even the most negative code
   assign a_re = in_re[IW-1] ? IW'(-in_re) : IW'(in_re);
   assign a_im = in_im[IW-1] ? IW'(-in_im) : IW'(in_im);
   assign hi = (a_re > a_im) ? a_re : a_im;
   assign lo = (a_re > a_im) ? a_im : a_re;

   always_comb begin
      st_next = st;
      if (in_valid) begin
         // max plus 3/8 min: no multiplier, error within about 7 percent
         st_next.mag = {1'h0, hi} + {3'h0, lo[IW-1:2]}
            + {4'h0, lo[IW-1:3]};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= st_next;
      end
   end

   assign mag = st.mag;

   a_mag_bounds:
   assert property (@(posedge clk) disable iff (rst)
      in_valid |=> (mag >= $past({1'h0, hi}))
      && (mag <= $past({1'h0, hi}) + $past({1'h0, lo})))
   else $error("magnitude estimate out of bounds");
endmodule

// *** src/dce_pkg.sv ***
package dce_pkg;
   localparam int SMP_W = 16;
   localparam int MAG_W = SMP_W + 1;
   localparam int DMAG_W = SMP_W + 3;
   localparam int BIAS_W = MAG_W + 1;
   localparam int SET_W = 12;
   localparam int CALC_W = 48;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NEV = 6;
   localparam int PCT_FULL = 32'h64;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_SL1 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_LIM = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_SL2 = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_UNR = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h1c;
   // status and flag bit positions
   localparam int EV_CHR_LSB = 0;
   localparam int EV_UNR_LSB = 3;
   localparam int FL_ANY_BIT = 6;
   // setting limits and reset values
   localparam logic [SET_W-1:0] BASE_MIN = 12'h00a;
   localparam logic [SET_W-1:0] BASE_MAX = 12'h032;
   localparam logic [SET_W-1:0] BASE_RST = 12'h014;
   localparam logic [SET_W-1:0] SL1_MIN = 12'h00a;
   localparam logic [SET_W-1:0] SL1_MAX = 12'h032;
   localparam logic [SET_W-1:0] SL1_RST = 12'h014;
   localparam logic [SET_W-1:0] LIM_MIN = 12'h0c8;
   localparam logic [SET_W-1:0] LIM_MAX = 12'h7d0;
   localparam logic [SET_W-1:0] LIM_RST = 12'h0c8;
   localparam logic [SET_W-1:0] SL2_MIN = 12'h01e;
   localparam logic [SET_W-1:0] SL2_MAX = 12'h0c8;
   localparam logic [SET_W-1:0] SL2_RST = 12'h0c8;
   localparam logic [SET_W-1:0] UNR_MIN = 12'h320;
   localparam logic [SET_W-1:0] UNR_MAX = 12'h9c4;
   localparam logic [SET_W-1:0] UNR_RST = 12'h320;
   localparam logic [NEV-1:0] MASK_RST = 6'h00;
   typedef logic [CALC_W-1:0] dce_calc_t;
   typedef logic [DATA_W-1:0] dce_data_t;
   typedef logic [SET_W-1:0] dce_set_t;
   typedef logic signed [SMP_W+1:0] dce_dsum_t;
   typedef logic [BIAS_W:0] dce_bsum_t;
   typedef struct packed {
      logic signed [SMP_W-1:0] re;
      logic signed [SMP_W-1:0] im;
   } dce_phasor_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dce_bus_req_s;
   typedef struct packed {
      dce_set_t base;
      dce_set_t sl1;
      dce_set_t lim;
      dce_set_t sl2;
      dce_set_t unr;
   } dce_set_s;
   typedef struct packed {
      dce_set_s set;
      logic [NEV-1:0] status;
      logic [NEV-1:0] mask;
      logic [DATA_W-1:0] rdata;
      logic va;
      logic vb;
      logic [2:0][DMAG_W-1:0] diff_b;
      logic [2:0][BIAS_W-1:0] bias;
      logic [2:0] chr;
      logic [2:0] unr;
      logic unr_any;
      logic irq;
   } dce_state_s;
   localparam dce_set_s SET_RST = '{base: BASE_RST, sl1: SL1_RST,
      lim: LIM_RST, sl2: SL2_RST, unr: UNR_RST};
   localparam dce_state_s ST_RST = '{set: SET_RST, status: '0,
      mask: MASK_RST, rdata: '0, va: 1'h0, vb: 1'h0, diff_b: '0,
      bias: '0, chr: 3'h0, unr: 3'h0, unr_any: 1'h0, irq: 1'h0};
endpackage

// *** src/dce_top.sv ***
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module dce_top #(
   parameter int NW = 3,
   parameter int IREF = 1000
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire dce_pkg::dce_bus_req_s bus_req,
   output logic [dce_pkg::DATA_W-1:0] bus_rdata,
   // phase-shifted samples, [winding][phase]
   input wire logic smp_valid,
   input wire dce_pkg::dce_phasor_s [NW-1:0][2:0] wind_smp,
   // magnitudes
   output logic [NW-1:0][2:0][dce_pkg::MAG_W-1:0] shifted_mag_phase,
   output logic [2:0][dce_pkg::DMAG_W-1:0] diff_mag_phase,
   output logic [2:0][dce_pkg::BIAS_W-1:0] bias_mag_phase,
   // start flags
   output logic [2:0] char_start_phase,
   output logic [2:0] unrestrained_start_phase,
   output logic unrestrained_start_any,
   // interrupt
   output logic irq
);
   localparam dce_pkg::dce_calc_t PCT =
      dce_pkg::dce_calc_t'(dce_pkg::PCT_FULL);
   localparam dce_pkg::dce_calc_t IREF_C = dce_pkg::dce_calc_t'(IREF);

   dce_pkg::dce_state_s st;
   dce_pkg::dce_state_s st_next;
   logic [2:0][dce_pkg::BIAS_W:0] bsum;
   logic [2:0][dce_pkg::CALC_W-1:0] thr;
   logic [2:0] chr_n;
   logic [2:0] unr_n;
   logic [dce_pkg::NEV-1:0] ev;

   function automatic dce_pkg::dce_set_t clamp(
      input dce_pkg::dce_data_t v,
      input dce_pkg::dce_set_t lo,
      input dce_pkg::dce_set_t hi);
      dce_pkg::dce_set_t r;
      if (v < dce_pkg::dce_data_t'(lo)) begin
         r = lo;
      end else if (v > dce_pkg::dce_data_t'(hi)) begin
         r = hi;
      end else begin
         r = v[dce_pkg::SET_W-1:0];
      end
      return r;
   endfunction

   // threshold scaled by 100*100 so no division is needed
   function automatic dce_pkg::dce_calc_t thresh(
      input logic [dce_pkg::BIAS_W-1:0] b,
      input dce_pkg::dce_set_s s);
      dce_pkg::dce_calc_t b100;
      dce_pkg::dce_calc_t lim100;
      dce_pkg::dce_calc_t flat;
      dce_pkg::dce_calc_t sec;
      b100 = dce_pkg::dce_calc_t'(b) * PCT;
      lim100 = dce_pkg::dce_calc_t'(s.lim) * IREF_C;
      flat = dce_pkg::dce_calc_t'(s.base) * IREF_C * PCT;
      if (b100 > lim100) begin
         sec = dce_pkg::dce_calc_t'(s.sl1) * lim100
            + dce_pkg::dce_calc_t'(s.sl2) * (b100 - lim100);
      end else begin
         sec = dce_pkg::dce_calc_t'(s.sl1) * b100;
      end
      // a high base keeps the floor even past the knee
      return (sec > flat) ? sec : flat;
   endfunction

   for (genvar p = 0; p < 3; p++) begin : g_ph
      dce_pkg::dce_dsum_t d_re;
      dce_pkg::dce_dsum_t d_im;
      for (genvar w = 0; w < NW; w++) begin : g_w
         dce_mag #(
            .IW(dce_pkg::SMP_W)
         ) u_mag (
            .clk(clk),
            .rst(rst),
            .in_valid(smp_valid),
            .in_re(wind_smp[w][p].re),
            .in_im(wind_smp[w][p].im),
            .mag(shifted_mag_phase[w][p])
         );
      end
      // tertiary terms exist only in the three-winding build
      if (NW == 3) begin : g_three
         assign d_re = dce_pkg::dce_dsum_t'(wind_smp[0][p].re)
            + dce_pkg::dce_dsum_t'(wind_smp[1][p].re)
            + dce_pkg::dce_dsum_t'(wind_smp[2][p].re);
         assign d_im = dce_pkg::dce_dsum_t'(wind_smp[0][p].im)
            + dce_pkg::dce_dsum_t'(wind_smp[1][p].im)
            + dce_pkg::dce_dsum_t'(wind_smp[2][p].im);
         assign bsum[p] = dce_pkg::dce_bsum_t'(shifted_mag_phase[0][p])
            + dce_pkg::dce_bsum_t'(shifted_mag_phase[1][p])
            + dce_pkg::dce_bsum_t'(shifted_mag_phase[2][p]);
      end else begin : g_two
         assign d_re = dce_pkg::dce_dsum_t'(wind_smp[0][p].re)
            + dce_pkg::dce_dsum_t'(wind_smp[1][p].re);
         assign d_im = dce_pkg::dce_dsum_t'(wind_smp[0][p].im)
            + dce_pkg::dce_dsum_t'(wind_smp[1][p].im);
         assign bsum[p] = dce_pkg::dce_bsum_t'(shifted_mag_phase[0][p])
            + dce_pkg::dce_bsum_t'(shifted_mag_phase[1][p]);
      end
      dce_mag #(
         .IW(dce_pkg::SMP_W + 2)
      ) u_dmag (
         .clk(clk),
         .rst(rst),
         .in_valid(smp_valid),
         .in_re(d_re),
         .in_im(d_im),
         .mag(diff_mag_phase[p])
      );
      // three-section line at the held bias
      assign thr[p] = thresh(st.bias[p], st.set);
      // above the line at present bias
      assign chr_n[p] = dce_pkg::dce_calc_t'(st.diff_b[p]) * PCT * PCT
         > thr[p];
      assign unr_n[p] = dce_pkg::dce_calc_t'(st.diff_b[p]) * PCT
         > dce_pkg::dce_calc_t'(st.set.unr) * IREF_C;
   end

   always_comb begin
      st_next = st;
      st_next.va = smp_valid;
      st_next.vb = st.va;
      st_next.rdata = '0;
      ev = '0;
      // one step per sample, stages held between samples
      if (st.va) begin
         for (int p = 0; p < 3; p++) begin
            st_next.diff_b[p] = diff_mag_phase[p];
            st_next.bias[p] = bsum[p][dce_pkg::BIAS_W:1];
         end
      end
      if (st.vb) begin
         st_next.chr = chr_n;
         st_next.unr = unr_n;
         st_next.unr_any = |unr_n;
         ev = {unr_n & ~st.unr, chr_n & ~st.chr};
      end
      if (bus_req.wr) begin
         case (bus_req.addr)
            dce_pkg::OFS_BASE: begin
               st_next.set.base = clamp(bus_req.wdata,
                  dce_pkg::BASE_MIN, dce_pkg::BASE_MAX);
            end
            dce_pkg::OFS_SL1: begin
               st_next.set.sl1 = clamp(bus_req.wdata,
                  dce_pkg::SL1_MIN, dce_pkg::SL1_MAX);
            end
            dce_pkg::OFS_LIM: begin
               st_next.set.lim = clamp(bus_req.wdata,
                  dce_pkg::LIM_MIN, dce_pkg::LIM_MAX);
            end
            dce_pkg::OFS_SL2: begin
               st_next.set.sl2 = clamp(bus_req.wdata,
                  dce_pkg::SL2_MIN, dce_pkg::SL2_MAX);
            end
            dce_pkg::OFS_UNR: begin
               st_next.set.unr = clamp(bus_req.wdata,
                  dce_pkg::UNR_MIN, dce_pkg::UNR_MAX);
            end
            dce_pkg::OFS_MASK: begin
               st_next.mask = bus_req.wdata[dce_pkg::NEV-1:0];
            end
            default: begin
            end
         endcase
      end
      if (bus_req.rd) begin
         case (bus_req.addr)
            dce_pkg::OFS_BASE: begin
               st_next.rdata = dce_pkg::dce_data_t'(st.set.base);
            end
            dce_pkg::OFS_SL1: begin
               st_next.rdata = dce_pkg::dce_data_t'(st.set.sl1);
            end
            dce_pkg::OFS_LIM: begin
               st_next.rdata = dce_pkg::dce_data_t'(st.set.lim);
            end
            dce_pkg::OFS_SL2: begin
               st_next.rdata = dce_pkg::dce_data_t'(st.set.sl2);
            end
            dce_pkg::OFS_UNR: begin
               st_next.rdata = dce_pkg::dce_data_t'(st.set.unr);
            end
            dce_pkg::OFS_STATUS: begin
               st_next.rdata = dce_pkg::dce_data_t'(st.status);
               st_next.status = '0;
            end
            dce_pkg::OFS_MASK: begin
               st_next.rdata = dce_pkg::dce_data_t'(st.mask);
            end
            dce_pkg::OFS_FLAGS: begin
               st_next.rdata = dce_pkg::dce_data_t'(
                  {st.unr_any, st.unr, st.chr});
            end
            default: begin
               st_next.rdata = '0;
            end
         endcase
      end
      // a new event beats the read-clear in the same cycle
      st_next.status = st_next.status | ev;
      st_next.irq = |(st_next.status & st_next.mask);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= dce_pkg::ST_RST;
      end else begin
         st <= st_next;
      end
   end

   assign bus_rdata = st.rdata;
   assign bias_mag_phase = st.bias;
   assign char_start_phase = st.chr;
   assign unrestrained_start_phase = st.unr;
   assign unrestrained_start_any = st.unr_any;
   assign irq = st.irq;

   default clocking dce_cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_bias_half:
   assert property (st.va |=> st.bias[1]
      == $past(bsum[1][dce_pkg::BIAS_W:1]))
   else $error("bias is not half the shifted sum");

   a_unr_any_or:
   assert property (unrestrained_start_any == |unrestrained_start_phase)
   else $error("general unrestrained start is not the phase OR");

   a_unr_level:
   assert property (st.vb |=> unrestrained_start_phase[2]
      == (dce_pkg::dce_calc_t'($past(st.diff_b[2])) * PCT
      > dce_pkg::dce_calc_t'($past(st.set.unr)) * IREF_C))
   else $error("unrestrained start disagrees with level");

   a_char_floor:
   assert property (st.vb && (dce_pkg::dce_calc_t'(st.diff_b[0]) * PCT
      <= dce_pkg::dce_calc_t'(st.set.base) * IREF_C)
      |=> !char_start_phase[0])
   else $error("start below base sensitivity");

   // flat run: first slope still under the floor, below the knee
   a_char_flat_run:
   assert property (st.vb
      && (dce_pkg::dce_calc_t'(st.bias[1]) * PCT
      <= dce_pkg::dce_calc_t'(st.set.lim) * IREF_C)
      && (dce_pkg::dce_calc_t'(st.set.sl1)
      * dce_pkg::dce_calc_t'(st.bias[1])
      <= dce_pkg::dce_calc_t'(st.set.base) * IREF_C)
      && (dce_pkg::dce_calc_t'(st.diff_b[1]) * PCT
      > dce_pkg::dce_calc_t'(st.set.base) * IREF_C)
      |=> char_start_phase[1])
   else $error("no start above base on the flat run");

   a_flags_hold:
   assert property (!st.vb |=> $stable(char_start_phase)
      && $stable(unrestrained_start_phase))
   else $error("flags changed without a sample");

   a_base_range:
   assert property (st.set.base >= dce_pkg::BASE_MIN
      && st.set.base <= dce_pkg::BASE_MAX)
   else $error("base sensitivity out of range");

   a_slope1_range:
   assert property (st.set.sl1 >= dce_pkg::SL1_MIN
      && st.set.sl1 <= dce_pkg::SL1_MAX)
   else $error("first slope out of range");

   a_limit_range:
   assert property (st.set.lim >= dce_pkg::LIM_MIN
      && st.set.lim <= dce_pkg::LIM_MAX)
   else $error("bias limit out of range");

   a_slope2_range:
   assert property (st.set.sl2 >= dce_pkg::SL2_MIN
      && st.set.sl2 <= dce_pkg::SL2_MAX)
   else $error("second slope out of range");

   a_unr_range:
   assert property (st.set.unr >= dce_pkg::UNR_MIN
      && st.set.unr <= dce_pkg::UNR_MAX)
   else $error("unrestrained level out of range");

   a_irq_level:
   assert property (irq == |(st.status & st.mask))
   else $error("interrupt does not follow masked status");

   // a status read right after the event may clear it legally
   a_event_sticky:
   assert property (st.vb && chr_n[0] && !st.chr[0]
      |=> st.status[dce_pkg::EV_CHR_LSB]
      ##1 (st.status[dce_pkg::EV_CHR_LSB]
      || $past(bus_req.rd && bus_req.addr == dce_pkg::OFS_STATUS)))
   else $error("start event not latched");

   c_char_start:
   cover property ($rose(char_start_phase[0]));

   c_unr_start:
   cover property ($rose(unrestrained_start_any));

   c_third_section:
   cover property (st.vb && (dce_pkg::dce_calc_t'(st.bias[2]) * PCT
      > dce_pkg::dce_calc_t'(st.set.lim) * IREF_C) && chr_n[2]);

   c_irq:
   cover property ($rose(irq));
endmodule

// *** verif/dce_src.sv ***
`timescale 1ns/1ps
module dce_src #(
   parameter int NW = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command from the bench
   input wire logic go,
   input wire dce_pkg::dce_phasor_s [NW-1:0][2:0] nxt,
   // sample stream
   output logic smp_valid,
   output dce_pkg::dce_phasor_s [NW-1:0][2:0] wind_smp
);
   // idle data keeps toggling so a stage that takes it unstrobed shows up
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         smp_valid <= 1'b0;
         wind_smp <= '0;
      end else begin
         smp_valid <= go;
         wind_smp <= go ? nxt : ~wind_smp;
      end
   end
endmodule

// *** verif/dce_top_tb.sv ***
`timescale 1ns/1ps
module dce_top_tb;
   localparam int IREF = 1000;
   localparam longint LO[5] = '{10, 10, 200, 30, 800};
   localparam longint HI[5] = '{50, 50, 2000, 200, 2500};
   localparam longint DEF[5] = '{20, 20, 200, 200, 800};
   localparam int DA[6] = '{1100, 1101, 8000, 8001, 0, 30000};
   localparam int DC[6] = '{900, 899, 0, 0, 0, 30000};
   typedef struct packed {
      logic [2:0][2:0][dce_pkg::MAG_W-1:0] m;
      logic [2:0][dce_pkg::DMAG_W-1:0] d;
      logic [2:0][dce_pkg::BIAS_W-1:0] b;
      logic [6:0] f;
      logic irq;
   } dce_exp_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic smp_valid;
   logic irq;
   logic any;
   logic [2:0] chr;
   logic [2:0] unr;
   logic [2:0] vp = 3'h0;
   logic rp = 1'b0;
   logic [5:0] st = 6'h00;
   logic [5:0] msk = 6'h00;
   logic [6:0] pf = 7'h00;
   logic [31:0] rdata;
   logic [2:0][2:0][dce_pkg::MAG_W-1:0] smag;
   logic [2:0][dce_pkg::DMAG_W-1:0] dmag;
   logic [2:0][dce_pkg::BIAS_W-1:0] bmag;
   logic [1:0][2:0][dce_pkg::MAG_W-1:0] smag2;
   logic [2:0][dce_pkg::DMAG_W-1:0] dmag2;
   logic [2:0][dce_pkg::BIAS_W-1:0] bmag2;
   logic [2:0] chr2;
   logic [2:0] unr2;
   logic any2;
   logic [2:0] tz = 3'h0;
   dce_pkg::dce_bus_req_s bus_req = '0;
   dce_pkg::dce_phasor_s [2:0][2:0] nxt = '0;
   dce_pkg::dce_phasor_s [2:0][2:0] wind_smp;
   dce_exp_s qm[$];
   dce_exp_s qb[$];
   dce_exp_s qf[$];
   dce_exp_s e;
   logic [31:0] qr[$];
   longint sv[5] = DEF;
   int errors = 0;
   int n_compared = 0;
   int seed = 9801;

   always #20 clk = ~clk;

   dce_src #(.NW(3)) src (.clk(clk), .rst(rst), .go(go), .nxt(nxt),
      .smp_valid(smp_valid), .wind_smp(wind_smp));
   dce_top #(.NW(3), .IREF(IREF)) dut (.clk(clk), .rst(rst),
      .bus_req(bus_req), .bus_rdata(rdata), .smp_valid(smp_valid),
      .wind_smp(wind_smp), .shifted_mag_phase(smag),
      .diff_mag_phase(dmag), .bias_mag_phase(bmag),
      .char_start_phase(chr), .unrestrained_start_phase(unr),
      .unrestrained_start_any(any), .irq(irq));
   // two-winding build: same answers whenever the tertiary is zero
   dce_top #(.NW(2), .IREF(IREF)) dut2 (.clk(clk), .rst(rst),
      .bus_req(bus_req), .bus_rdata(), .smp_valid(smp_valid),
      .wind_smp(wind_smp[1:0]), .shifted_mag_phase(smag2),
      .diff_mag_phase(dmag2), .bias_mag_phase(bmag2),
      .char_start_phase(chr2), .unrestrained_start_phase(unr2),
      .unrestrained_start_any(any2), .irq());

   task automatic check(string nm, logic [159:0] x, logic [159:0] g);
      n_compared++;
      if (g !== x) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // drops both strobes, then waits n edges, so strobes are never set twice
   task automatic idle(int n);
      bus_req <= '0;
      go <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] x);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      qr.push_back(x);
      @(posedge clk);
   endtask

   task automatic setw(int i, longint v);
      sv[i] = v < LO[i] ? LO[i] : v > HI[i] ? HI[i] : v;
      wr(8'(4 * i), 32'(v));
   endtask

   function automatic longint est(longint x, longint y);
      longint a;
      longint c;
      a = x < 0 ? -x : x;
      c = y < 0 ? -y : y;
      return a > c ? a + (c >> 2) + (c >> 3) : c + (a >> 2) + (a >> 3);
   endfunction

   task automatic send(dce_pkg::dce_phasor_s [2:0][2:0] ph);
      dce_exp_s x;
      longint sr, si, b, t, k, d;
      for (int p = 0; p < 3; p++) begin
         sr = 0;
         si = 0;
         b = 0;
         for (int w = 0; w < 3; w++) begin
            x.m[w][p] = 17'(est(ph[w][p].re, ph[w][p].im));
            b += est(ph[w][p].re, ph[w][p].im);
            sr += ph[w][p].re;
            si += ph[w][p].im;
         end
         d = est(sr, si);
         b = b >> 1;
         x.d[p] = 19'(d);
         x.b[p] = 18'(b);
         k = sv[2] * IREF;
         // one rounding only, as two floors can sit a count low
         t = b * 100 <= k ? sv[1] * b / 100
            : (sv[1] * k + sv[3] * (b * 100 - k)) / 10000;
         if (t < sv[0] * IREF / 100)
            t = sv[0] * IREF / 100;
         x.f[p] = d > t;
         x.f[p + 3] = d * 100 > sv[4] * IREF;
      end
      x.f[6] = |x.f[5:3];
      st = st | (x.f[5:0] & ~pf[5:0]);
      pf = x.f;
      x.irq = |(st & msk);
      qm.push_back(x);
      qb.push_back(x);
      qf.push_back(x);
      nxt <= ph;
      go <= 1'b1;
      @(posedge clk);
   endtask

   task automatic rnd(int sh);
      dce_pkg::dce_phasor_s [2:0][2:0] ph;
      foreach (ph[w, p]) begin
         ph[w][p].re = 16'($random(seed)) >>> sh;
         ph[w][p].im = 16'($random(seed)) >>> sh;
      end
      send(ph);
   endtask

   always @(posedge clk) begin
      vp <= {vp[1:0], smp_valid};
      tz <= {tz[1:0], wind_smp[2] == '0};
      rp <= bus_req.rd;
   end

   always @(negedge clk) begin
      if (rp)
         check("rdata", qr.pop_front(), rdata);
      else
         check("rdata idle", 32'h0, rdata);
      if (vp[0]) begin
         e = qm.pop_front();
         check("shifted", e.m, smag);
         check("diff", e.d, dmag);
         if (tz[0]) begin
            check("shifted two", e.m[1:0], smag2);
            check("diff two", e.d, dmag2);
         end
      end
      if (vp[1]) begin
         e = qb.pop_front();
         check("bias", e.b, bmag);
         if (tz[1])
            check("bias two", e.b, bmag2);
      end
      if (vp[2]) begin
         e = qf.pop_front();
         check("char", e.f[2:0], chr);
         check("unr", e.f[5:3], unr);
         check("any", e.f[6], any);
         if (tz[2])
            check("flags two", e.f, {any2, unr2, chr2});
         check("irq", e.irq, irq);
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      results();
   end

   initial begin
      dce_pkg::dce_phasor_s [2:0][2:0] ph;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 5; i++)
         rd(8'(4 * i), 32'(DEF[i]));
      rd(8'h18, 32'h0);
      rd(8'h14, 32'h0);
      wr(8'h1c, 32'h7f);
      rd(8'h1c, 32'h0);
      rd(8'h20, 32'h0);
      idle(2);
      $display("test reset values done");
      // strict compare: at the line and two counts above it below the knee, then at and one count above the unrestrained level
      for (int i = 0; i < 6; i++) begin
         ph = '0;
         for (int p = 0; p < 3; p++) begin
            ph[0][p].re = 16'(DA[i]);
            ph[1][p].re = -16'(DC[i]);
         end
         send(ph);
      end
      idle(4);
      rd(8'h14, {26'h0, st});
      st = 6'h00;
      rd(8'h1c, {25'h0, pf});
      idle(2);
      $display("test threshold edges done");
      for (int i = 0; i < 5; i++) begin
         setw(i, LO[i] - 1);
         rd(8'(4 * i), 32'(sv[i]));
         setw(i, HI[i] + 1);
         rd(8'(4 * i), 32'(sv[i]));
         setw(i, LO[i] + {$random(seed)} % (HI[i] - LO[i] + 1));
         rd(8'(4 * i), 32'(sv[i]));
      end
      idle(2);
      $display("test setting limits done");
      for (int b = 0; b < 4; b++) begin
         msk = b[0] ? 6'h38 : 6'h3f;
         wr(8'h18, {26'h0, msk});
         for (int i = 0; i < 5; i++)
            setw(i, LO[i] + {$random(seed)} % (HI[i] - LO[i] + 1));
         idle(2);
         for (int k = 0; k < 25; k++) begin
            rnd(k % 11);
            if (k % 7 == 3)
               idle(1);
         end
         idle(4);
         rd(8'h14, {26'h0, st});
         st = 6'h00;
         rd(8'h1c, {25'h0, pf});
         idle(3);
         @(negedge clk);
         check("irq cleared", 1'b0, irq);
         @(posedge clk);
         $display("test batch %0d done", b);
      end
      rnd(0);
      idle(4);
      rst <= 1'b1;
      idle(2);
      @(negedge clk);
      check("flags", 7'h00, {any, unr, chr});
      check("irq", 1'b0, irq);
      @(posedge clk);
      rst <= 1'b0;
      sv = DEF;
      pf = 7'h00;
      msk = 6'h00;
      st = 6'h00;
      @(posedge clk);
      rd(8'h00, 32'(DEF[0]));
      rd(8'h14, 32'h0);
      rd(8'h18, 32'h0);
      idle(2);
      $display("test mid-run reset done");
      results();
   end
endmodule
